// file: src/dpx_pkg.sv
// Constants, types and the register map of the data-processing execution-control block
package dpx_pkg;
	// Register byte offsets on the AXI4-Lite port
	localparam logic [7:0] OFF_INSTR = 8'h00;
	localparam logic [7:0] OFF_IADDR = 8'h04;
	localparam logic [7:0] OFF_OPND = 8'h08;
	localparam logic [7:0] OFF_ALU_RES = 8'h0c;
	localparam logic [7:0] OFF_ALU_CV = 8'h10;
	localparam logic [7:0] OFF_CUR = 8'h14;
	localparam logic [7:0] OFF_SAVED = 8'h18;
	localparam logic [7:0] OFF_PC_OPND = 8'h1c;
	localparam logic [7:0] OFF_DEST = 8'h20;
	localparam logic [7:0] OFF_EXEC = 8'h24;
	// Program counter lead over the instruction address
	localparam logic [31:0] PC_AHEAD_IMM = 32'h0000_0008;
	localparam logic [31:0] PC_AHEAD_REG = 32'h0000_000c;
	// Status word layout
	localparam logic [31:0] CUR_RESET = 32'h0000_00d3;
	localparam logic [31:0] SAVED_RESET = 32'h0000_0000;
	localparam int BIT_N = 31;
	localparam int BIT_Z = 30;
	localparam int BIT_C = 29;
	localparam int BIT_V = 28;
	// Processor modes held in status bits 4:0
	localparam logic [4:0] MODE_USR = 5'h10;
	localparam logic [4:0] MODE_FIQ = 5'h11;
	localparam logic [4:0] MODE_IRQ = 5'h12;
	localparam logic [4:0] MODE_SVC = 5'h13;
	localparam logic [4:0] MODE_ABT = 5'h17;
	localparam logic [4:0] MODE_UND = 5'h1b;
	localparam int NUM_BANKS = 5;
	// Opcodes, register numbers and response codes
	localparam logic [3:0] OP_XOR_TEST = 4'h9;
	localparam logic [3:0] REG_PC = 4'hf;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Incremental cycle counts
	localparam logic [1:0] CYC_S_PLAIN = 2'h1;
	localparam logic [1:0] CYC_S_PC = 2'h2;

	typedef enum logic [1:0]
	{
		ST_IDLE = 2'h0,
		ST_EXEC = 2'h1,
		ST_DONE = 2'h3
	} dpx_state_t;

	// Outcome of the last instruction, low bits of the execution register
	typedef struct packed
	{
		logic executed;
		logic wr_dest;
		logic wr_pc;
		logic [1:0] s_cyc;
		logic n_cyc;
		logic i_cyc;
	} dpx_exec_t;
endpackage

// file: src/dpx_cond_eval.sv
// Condition field evaluator against the N, Z, C and V flags
`timescale 1ns/1ns
module dpx_cond_eval
	import dpx_pkg::*;
(
	input wire logic [3:0] cond,
	input wire logic [3:0] flags,
	output logic pass
);
	logic n;
	logic z;
	logic c;
	logic v;

	assign {n, z, c, v} = flags;

	// Sixteen condition codes, 1111 treated as always
	always_comb
	begin
		unique case (cond)
			4'h0: pass = z;
			4'h1: pass = !z;
			4'h2: pass = c;
			4'h3: pass = !c;
			4'h4: pass = n;
			4'h5: pass = !n;
			4'h6: pass = v;
			4'h7: pass = !v;
			4'h8: pass = c && !z;
			4'h9: pass = !c || z;
			4'ha: pass = n == v;
			4'hb: pass = n != v;
			4'hc: pass = !z && (n == v);
			4'hd: pass = z || (n != v);
			4'he: pass = 1'b1;
			4'hf: pass = 1'b1;
		endcase
	end
endmodule // dpx_cond_eval

// file: src/dpx_exec_ctrl.sv
// Data-processing execution control: PC operand, compares, cycle costs, status transfers
//
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ns
// Functional notes
// - PC operand with immediate shift reads instruction address plus 8
// - PC operand with register shift reads instruction address plus 12
// - Compare-class opcodes set flags and never write a destination
// - Legacy xor-test restore copies saved to current when privileged only
// - No PC write: 1S, plus 1I with register shift
// - Immediate shift writing PC: 2S plus 1N
// - Register shift writing PC: 2S plus 1N plus 1I
// - Status transfer runs only when its condition passes
// - Compare opcodes with flag-update clear decode as status transfers
// - Status-to-register move copies current or saved word to destination
// - Register-to-status move writes current or saved word
// - Flag-only form writes top four bits, keeps control bits
// - User mode cannot change control bits of the current word
// - Privileged modes may write every bit of the current word
// - Saved word bank is the one of the mode at execution
// - Arithmetic flags: Z when result zero, N is result bit 31
// - Flag-setting write to PC restores saved word into current word
module dpx_exec_ctrl
	import dpx_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic awvalid,
	output logic awready,
	input wire logic [7:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [7:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp
);
	logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff, aw_got_ff, w_got_ff;
	logic [1:0] bresp_ff, rresp_ff, alu_cv_ff;
	logic [31:0] rdata_ff, wdata_ff, rd_mux;
	logic [7:0] awaddr_ff;
	logic [3:0] wstrb_ff, opcode, rd;
	logic aw_hs, w_hs, ar_hs, wr_fire, wr_hit, rd_hit, bank_we, bank_ok, cond_pass, go;
	logic [31:0] instr_ff, iaddr_ff, opnd_ff, alu_res_ff, cur_ff, dest_ff, pcop_ff;
	dpx_exec_t exec_ff, nxt_exec;
	dpx_state_t state_ff;
	logic [31:0] nxt_cur, nxt_dest, bank_wdata, saved_val, imm32, src, xfer_word;
	logic [2:0] bank_idx;
	logic [NUM_BANKS-1:0][31:0] bank_q;
	logic s_bit, imm_op, reg_shift, is_dp, is_cmp, is_xfer, use_saved, to_status;
	logic full_form, wr_pc, legacy, user_mode;
	assign awready = awready_ff;
	assign wready = wready_ff;
	assign bvalid = bvalid_ff;
	assign bresp = bresp_ff;
	assign arready = arready_ff;
	assign rvalid = rvalid_ff;
	assign rdata = rdata_ff;
	assign rresp = rresp_ff;
	// Merge new bytes into an old word under byte strobes
	function automatic logic [31:0] merge_strb(logic [31:0] old, logic [31:0] nw, logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (st[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		return r;
	endfunction
	// Instruction fields
	assign opcode = instr_ff[24:21];
	assign s_bit = instr_ff[20];
	assign imm_op = instr_ff[25];
	assign reg_shift = !imm_op && instr_ff[4];
	assign rd = instr_ff[15:12];
	assign is_dp = instr_ff[27:26] == 2'h0;
	assign is_cmp = opcode[3:2] == 2'h2;
	assign is_xfer = is_cmp && !s_bit;
	assign use_saved = instr_ff[22];
	assign to_status = instr_ff[21];
	assign full_form = instr_ff[16];
	assign wr_pc = !is_cmp && rd == REG_PC;
	assign legacy = opcode == OP_XOR_TEST && s_bit && rd == REG_PC;
	assign user_mode = cur_ff[4:0] == MODE_USR;
	assign imm32 = 32'({24'h0, instr_ff[7:0], 24'h0, instr_ff[7:0]} >> {instr_ff[11:8], 1'b0});
	assign src = imm_op ? imm32 : opnd_ff;
	assign go = state_ff == ST_EXEC && is_dp && cond_pass;
	// Saved bank of the mode active now; user and system have none
	always_comb
	begin
		bank_ok = 1'b1;
		bank_idx = 3'h0;
		unique case (cur_ff[4:0])
			MODE_FIQ: bank_idx = 3'h0;
			MODE_IRQ: bank_idx = 3'h1;
			MODE_SVC: bank_idx = 3'h2;
			MODE_ABT: bank_idx = 3'h3;
			MODE_UND: bank_idx = 3'h4;
			default: bank_ok = 1'b0;
		endcase
	end
	assign saved_val = bank_q[bank_idx];
	assign xfer_word = use_saved ? saved_val : cur_ff;
	dpx_cond_eval u_cond
	(
		.cond(instr_ff[31:28]),
		.flags(cur_ff[31:28]),
		.pass(cond_pass)
	);
	// Execution outcome for the instruction in the execute state
	always_comb
	begin
		nxt_cur = cur_ff;
		nxt_dest = dest_ff;
		nxt_exec = '0;
		bank_we = 1'b0;
		bank_wdata = saved_val;
		if (go && is_xfer)
		begin
			nxt_exec.executed = 1'b1;
			nxt_exec.s_cyc = CYC_S_PLAIN;
			if (use_saved && !bank_ok)
				nxt_exec.executed = 1'b0;
			else if (!to_status)
			begin
				nxt_dest = xfer_word;
				nxt_exec.wr_dest = 1'b1;
			end
			else
			begin
				// Flag-only form keeps bits 27:0 of the target word
				bank_wdata = full_form ? src : {src[31:28], xfer_word[27:0]};
				if (use_saved)
					bank_we = 1'b1;
				else if (user_mode)
					nxt_cur = {bank_wdata[31:28], cur_ff[27:0]};
				else
					nxt_cur = bank_wdata;
			end
		end
		else if (go)
		begin
			nxt_exec.executed = 1'b1;
			nxt_exec.wr_pc = wr_pc;
			nxt_exec.s_cyc = wr_pc ? CYC_S_PC : CYC_S_PLAIN;
			nxt_exec.n_cyc = wr_pc;
			nxt_exec.i_cyc = reg_shift;
			if (legacy || (s_bit && wr_pc))
				nxt_cur = bank_ok ? saved_val : cur_ff;
			else if (s_bit)
			begin
				nxt_cur[BIT_N] = alu_res_ff[31];
				nxt_cur[BIT_Z] = alu_res_ff == 32'h0;
				nxt_cur[BIT_C] = alu_cv_ff[1];
				nxt_cur[BIT_V] = alu_cv_ff[0];
			end
			if (!is_cmp)
			begin
				nxt_dest = alu_res_ff;
				nxt_exec.wr_dest = 1'b1;
			end
		end
	end
	// Execute sequencing: start on a write of the instruction register
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			state_ff <= ST_IDLE;
		else
		begin
			unique case (state_ff)
				ST_IDLE: state_ff <= (wr_fire && awaddr_ff == OFF_INSTR) ? ST_EXEC : ST_IDLE;
				ST_EXEC: state_ff <= ST_DONE;
				ST_DONE: state_ff <= (wr_fire && awaddr_ff == OFF_INSTR) ? ST_EXEC : ST_IDLE;
			endcase
		end
	end
	// Results of execution
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dest_ff <= 32'h0;
			exec_ff <= '0;
			pcop_ff <= 32'h0;
		end
		else if (state_ff == ST_EXEC)
		begin
			dest_ff <= nxt_dest;
			exec_ff <= nxt_exec;
			pcop_ff <= iaddr_ff + (reg_shift ? PC_AHEAD_REG : PC_AHEAD_IMM);
		end
	end
	// Current status word: execution first, then software
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			cur_ff <= CUR_RESET;
		else if (state_ff == ST_EXEC)
			cur_ff <= nxt_cur;
		else if (wr_fire && awaddr_ff == OFF_CUR)
			cur_ff <= merge_strb(cur_ff, wdata_ff, wstrb_ff);
	end
	// Saved status banks, one per privileged mode except system
	for (genvar g = 0; g < NUM_BANKS; g++)
	begin : g_bank
		logic [31:0] bank_ff;
		always_ff @(posedge ref_clk or negedge rst_n)
		begin
			if (!rst_n)
				bank_ff <= SAVED_RESET;
			else if (bank_idx == 3'(g) && bank_ok && bank_we)
				bank_ff <= bank_wdata;
			else if (bank_idx == 3'(g) && bank_ok && wr_fire && awaddr_ff == OFF_SAVED)
				bank_ff <= merge_strb(bank_ff, wdata_ff, wstrb_ff);
		end
		assign bank_q[g] = bank_ff;
	end
	// Software-loaded instruction, operand and ALU result registers
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			instr_ff <= 32'h0;
			iaddr_ff <= 32'h0;
			opnd_ff <= 32'h0;
			alu_res_ff <= 32'h0;
			alu_cv_ff <= 2'h0;
		end
		else if (wr_fire)
		begin
			unique case (awaddr_ff)
				OFF_INSTR: instr_ff <= merge_strb(instr_ff, wdata_ff, wstrb_ff);
				OFF_IADDR: iaddr_ff <= merge_strb(iaddr_ff, wdata_ff, wstrb_ff);
				OFF_OPND: opnd_ff <= merge_strb(opnd_ff, wdata_ff, wstrb_ff);
				OFF_ALU_RES: alu_res_ff <= merge_strb(alu_res_ff, wdata_ff, wstrb_ff);
				OFF_ALU_CV: alu_cv_ff <= wstrb_ff[0] ? wdata_ff[1:0] : alu_cv_ff;
				default: ;
			endcase
		end
	end
	// AXI4-Lite write address and data capture, in either order
	assign aw_hs = awvalid && awready_ff;
	assign w_hs = wvalid && wready_ff;
	assign wr_fire = aw_got_ff && w_got_ff && !bvalid_ff;
	assign wr_hit = awaddr_ff <= OFF_SAVED && awaddr_ff[1:0] == 2'h0;
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			aw_got_ff <= 1'b0;
			w_got_ff <= 1'b0;
			awready_ff <= 1'b0;
			wready_ff <= 1'b0;
			awaddr_ff <= 8'h0;
			wdata_ff <= 32'h0;
			wstrb_ff <= 4'h0;
		end
		else
		begin
			aw_got_ff <= aw_hs || (aw_got_ff && !wr_fire);
			w_got_ff <= w_hs || (w_got_ff && !wr_fire);
			awready_ff <= !(aw_hs || (aw_got_ff && !wr_fire));
			wready_ff <= !(w_hs || (w_got_ff && !wr_fire));
			if (aw_hs)
				awaddr_ff <= awaddr;
			if (w_hs)
			begin
				wdata_ff <= wdata;
				wstrb_ff <= wstrb;
			end
		end
	end
	// Write response one cycle after both halves are held
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bvalid_ff <= 1'b0;
			bresp_ff <= RESP_OKAY;
		end
		else if (wr_fire)
		begin
			bvalid_ff <= 1'b1;
			bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (bready)
			bvalid_ff <= 1'b0;
	end
	// Read data selection
	assign rd_hit = araddr <= OFF_EXEC && araddr[1:0] == 2'h0;
	always_comb
	begin
		unique case (araddr)
			OFF_INSTR: rd_mux = instr_ff;
			OFF_IADDR: rd_mux = iaddr_ff;
			OFF_OPND: rd_mux = opnd_ff;
			OFF_ALU_RES: rd_mux = alu_res_ff;
			OFF_ALU_CV: rd_mux = {30'h0, alu_cv_ff};
			OFF_CUR: rd_mux = cur_ff;
			OFF_SAVED: rd_mux = bank_ok ? saved_val : 32'h0;
			OFF_PC_OPND: rd_mux = pcop_ff;
			OFF_DEST: rd_mux = dest_ff;
			OFF_EXEC: rd_mux = {25'h0, exec_ff};
			default: rd_mux = 32'h0;
		endcase
	end
	// Read channel: one read outstanding, answer the cycle after the address
	assign ar_hs = arvalid && arready_ff;
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0;
			rresp_ff <= RESP_OKAY;
		end
		else
		begin
			arready_ff <= !(ar_hs || (rvalid_ff && !rready));
			if (ar_hs)
			begin
				rvalid_ff <= 1'b1;
				rdata_ff <= rd_mux;
				rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end
			else if (rready)
				rvalid_ff <= 1'b0;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	pc_imm_a: assert property (state_ff == ST_EXEC && !reg_shift
		|=> pcop_ff == $past(iaddr_ff) + 32'h8) else $error("PC operand not address plus 8");
	pc_reg_a: assert property (state_ff == ST_EXEC && reg_shift
		|=> pcop_ff == $past(iaddr_ff) + 32'hc) else $error("PC operand not address plus 12");
	cmp_nowrite_a: assert property (state_ff == ST_EXEC && is_cmp && s_bit
		|=> !exec_ff.wr_dest && dest_ff == $past(dest_ff)) else $error("Compare wrote a result");
	legacy_user_a: assert property (go && legacy && user_mode
		|=> $stable(cur_ff)) else $error("Legacy restore changed user status");
	cycle_cost_a: assert property (go && !is_xfer |=> exec_ff.s_cyc == ($past(wr_pc) ? 2'h2 : 2'h1)
		&& exec_ff.n_cyc == $past(wr_pc) && exec_ff.i_cyc == $past(reg_shift))
		else $error("Cycle cost wrong");
	cond_fail_a: assert property (state_ff == ST_EXEC && !cond_pass
		|=> !exec_ff.executed && $stable(cur_ff) && $stable(dest_ff))
		else $error("Failed condition acted");
	move_out_a: assert property (go && is_xfer && !to_status && !use_saved
		|=> dest_ff == $past(cur_ff) && exec_ff.wr_dest) else $error("Status move to register wrong");
	user_ctrl_a: assert property (state_ff == ST_EXEC && user_mode
		|=> cur_ff[27:0] == $past(cur_ff[27:0])) else $error("User changed control bits");
	zero_flag_a: assert property (go && !is_xfer && is_cmp && !legacy
		|=> cur_ff[BIT_Z] == ($past(alu_res_ff) == 32'h0) && cur_ff[BIT_N] == $past(alu_res_ff[31]))
		else $error("Arithmetic flags wrong");
	no_bank_a: assert property (go && is_xfer && use_saved && !bank_ok
		|=> $stable(cur_ff) && !exec_ff.wr_dest) else $error("Missing bank transfer acted");

	xfer_cov: cover property (go && is_xfer && to_status && !full_form);
	restore_cov: cover property (go && s_bit && wr_pc && bank_ok);
	regshift_pc_cov: cover property (go && wr_pc && reg_shift);
endmodule // dpx_exec_ctrl

// file: tb/dp_timing_and_psr_transfer_tb_top.sv
// Self-checking bench for the execution-control block over its AXI4-Lite port
`timescale 1ns/1ns
`define CHK(g, e) check_eq(g, e)
module dp_timing_and_psr_transfer_tb_top
	import dpx_pkg::*;
	;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic awvalid = 1'b0;
	logic awready;
	logic [7:0] awaddr = 8'h00;
	logic wvalid = 1'b0;
	logic wready;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0] wstrb = 4'hf;
	logic bvalid;
	logic bready = 1'b0;
	logic [1:0] bresp;
	logic arvalid = 1'b0;
	logic arready;
	logic [7:0] araddr = 8'h00;
	logic rvalid;
	logic rready = 1'b0;
	logic [31:0] rdata;
	logic [1:0] rresp;
	int failures = 0;
	int num_checks = 0;
	int cycles = 0;
	// PC-operand instructions: imm shift, reg shift, then both again writing the PC
	logic [31:0] pc_ops [4] = '{32'he08f1000, 32'he08f1210, 32'he08ff000, 32'he08ff210};
	logic [4:0] cyc_exp [4] = '{5'h04, 5'h05, 5'h1a, 5'h1b};

	dpx_exec_ctrl u_dpx_exec_ctrl (.ref_clk(ref_clk), .rst_n(rst_n), .awvalid(awvalid),
		.awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
		.wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
		.arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
		.rresp(rresp));

	// Clock generation
	always #20 ref_clk = ~ref_clk;

	// Verdict and end of run
	task automatic tally_and_finish();
		if (failures == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Hang guard
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			failures++;
			tally_and_finish();
		end
	end

	// Compare two words, four-state exact
	task automatic check_eq(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e)
		begin
			failures++;
			$display("MISMATCH at %0t got %h expected %h", $time, g, e);
		end
	endtask

	// Write cycle: address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
		@(posedge ref_clk);
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		awaddr <= a;
		wdata <= d;
		bready <= 1'b1;
		do
		begin
			@(posedge ref_clk);
			if (awready === 1'b1)
				awvalid <= 1'b0;
			if (wready === 1'b1)
				wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1);
		bready <= 1'b0;
		`CHK({30'h0, bresp}, {30'h0, er});
	endtask

	// Read cycle with masked data compare
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1,
		input logic [1:0] er = RESP_OKAY);
		@(posedge ref_clk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		do
		begin
			@(posedge ref_clk);
			if (arready === 1'b1)
				arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1);
		rready <= 1'b0;
		`CHK(rdata & m, e);
		`CHK({30'h0, rresp}, {30'h0, er});
	endtask

	// Set up status, operand and ALU outputs, then issue one instruction
	task automatic run(input logic [31:0] op, input logic [31:0] cur, input logic [31:0] opnd,
		input logic [31:0] res, input logic [31:0] cv);
		wr(OFF_CUR, cur);
		wr(OFF_OPND, opnd);
		wr(OFF_ALU_RES, res);
		wr(OFF_ALU_CV, cv);
		wr(OFF_INSTR, op);
		@(posedge ref_clk);
	endtask

	// Main sequence
	initial
	begin
		repeat (8) @(posedge ref_clk);
		rst_n <= 1'b1;
		rd(OFF_CUR, CUR_RESET);
		rd(OFF_SAVED, SAVED_RESET);
		rd(8'h28, 32'h0, '1, RESP_SLVERR);
		wr(OFF_PC_OPND, 32'h1, RESP_SLVERR);
		rd(OFF_PC_OPND, 32'h0);
		// PC lead and incremental cycle costs
		for (int i = 0; i < 4; i++)
		begin
			wr(OFF_IADDR, 32'h1000 + 32'(16 * i));
			run(pc_ops[i], CUR_RESET, 32'h0, 32'h0, 32'h0);
			rd(OFF_PC_OPND, 32'h1000 + 32'(16 * i) + ((i % 2) ? 32'hc : 32'h8));
			rd(OFF_EXEC, {27'h0, cyc_exp[i]}, 32'h1f);
			rd(OFF_CUR, CUR_RESET);
		end
		// Compare-class opcodes set flags but never write a result
		for (int k = 0; k < 4; k++)
		begin
			run({4'he, 3'b000, 4'h8 + 4'(k), 1'b1, 4'h2, 4'h1, 12'h000}, CUR_RESET, 32'h0,
				(k % 2) ? 32'h8000_0000 : 32'h0, 32'h0);
			rd(OFF_CUR, (k % 2) ? 32'h8000_0000 : 32'h4000_0000, 32'hc000_0000);
			rd(OFF_EXEC, 32'h40, 32'h60);
		end
		// Failing condition leaves everything alone
		run(32'h0129f000, 32'hd3, 32'hd7, 32'h0, 32'h0);
		rd(OFF_CUR, 32'hd3);
		rd(OFF_EXEC, 32'h0, 32'h40);
		// Full writes of current and saved words in privileged modes, then moves of both to a register
		run(32'he129f000, 32'hd3, 32'hd7, 32'h0, 32'h0);
		rd(OFF_CUR, 32'hd7);
		run(32'he169f000, 32'hd7, 32'h6000_00d1, 32'h0, 32'h0);
		rd(OFF_SAVED, 32'h6000_00d1);
		wr(OFF_CUR, 32'hd2);
		rd(OFF_SAVED, 32'h0);
		run(32'he169f000, 32'hd1, 32'h9000_00d3, 32'h0, 32'h0);
		rd(OFF_SAVED, 32'h9000_00d3);
		wr(OFF_CUR, 32'hdb);
		rd(OFF_SAVED, 32'h0);
		run(32'he14f1000, 32'hd7, 32'h0, 32'h0, 32'h0);
		rd(OFF_DEST, 32'h6000_00d1);
		run(32'he10f1000, 32'h2000_00d2, 32'h0, 32'h0, 32'h0);
		rd(OFF_DEST, 32'h2000_00d2);
		// Flag-setting PC write and legacy restore copy the saved word
		run(32'he1b0f000, 32'hd7, 32'h0, 32'h0, 32'h0);
		rd(OFF_CUR, 32'h6000_00d1);
		run(32'he139f000, 32'hd7, 32'h0, 32'h0, 32'h0);
		rd(OFF_CUR, 32'h6000_00d1);
		run(32'he139f000, 32'h10, 32'h0, 32'h0, 32'h0);
		rd(OFF_CUR, 32'h10);
		// User mode protection and missing bank
		run(32'he129f000, 32'h10, 32'hf000_00d3, 32'h0, 32'h0);
		rd(OFF_CUR, 32'hf000_0010);
		run(32'he169f000, 32'h10, 32'h1234_5678, 32'h0, 32'h0);
		rd(OFF_SAVED, 32'h0);
		rd(OFF_CUR, 32'h10);
		// Flag-only writes from register and rotated immediate
		run(32'he128f000, 32'hd3, 32'h5000_001f, 32'h0, 32'h0);
		rd(OFF_CUR, 32'h5000_00d3);
		run(32'he328f20f, 32'hd3, 32'h0, 32'h0, 32'h0);
		rd(OFF_CUR, 32'hf000_00d3);
		tally_and_finish();
	end
endmodule // dp_timing_and_psr_transfer_tb_top
